// File: hdl/lcr_pkg.sv
package lcr_pkg;
   localparam logic [7:0] ADDR_CH2_OUT_EMPHASIS = 8'h1F;
   localparam logic [7:0] ADDR_CH2_IDLE_THRESHOLD = 8'h20;
   localparam logic [7:0] ADDR_CH3_IDLE_RATE_SELECT = 8'h23;
   localparam logic [7:0] ADDR_CH3_RX_EQUALIZER = 8'h24;
   localparam logic [7:0] ADDR_CH3_OUT_SWING = 8'h25;
   localparam logic [7:0] RST_OUT_EMPHASIS = 8'h03;
   localparam logic [7:0] RST_IDLE_THRESHOLD = 8'h00;
   localparam logic [7:0] RST_IDLE_RATE_SELECT = 8'h00;
   localparam logic [7:0] RST_RX_EQUALIZER = 8'h20;
   localparam logic [7:0] RST_OUT_SWING = 8'h03;
   // Writable bit masks; reserved bits store and read zero
   localparam logic [7:0] MASK_OUT_EMPHASIS = 8'hFF;
   localparam logic [7:0] MASK_IDLE_THRESHOLD = 8'h0F;
   localparam logic [7:0] MASK_IDLE_RATE_SELECT = 8'h33;
   localparam logic [7:0] MASK_RX_EQUALIZER = 8'h3F;
   localparam logic [7:0] MASK_OUT_SWING = 8'h3F;
   localparam int EMPH_TYPE_BIT = 7;
   localparam int IDLE_AUTO_BIT = 5;
   localparam int IDLE_MUTE_BIT = 4;
   localparam int RATE_AUTO_BIT = 1;
   localparam int RATE_HIGH_BIT = 0;
   localparam int EQ_ENABLE_BIT = 5;
   localparam int EQ_STAGE_MSB = 4;
   localparam int EQ_STAGE_LSB = 3;
   localparam int EQ_BOOST_MSB = 2;
   localparam int THR_DEASSERT_MSB = 3;
   localparam int THR_DEASSERT_LSB = 2;
   localparam int THR_ASSERT_MSB = 1;
   // Emphasis codes
   localparam logic [7:0] EMPH_0DB = 8'h01;
   localparam logic [7:0] EMPH_3P5DB = 8'h38;
   localparam logic [7:0] EMPH_6DB = 8'h88;
   localparam logic [7:0] EMPH_9DB = 8'h90;
   localparam logic [7:0] EMPH_12DB = 8'hA0;
   localparam logic [7:0] EMPH_RESERVED = 8'hC0;
   // Equalizer codes
   localparam logic [5:0] EQ_BYPASS = 6'h20;
   localparam logic [5:0] EQ_CODE_2A = 6'h2A;
   localparam logic [5:0] EQ_CODE_30 = 6'h30;
   localparam logic [5:0] EQ_CODE_31 = 6'h31;
   localparam logic [5:0] EQ_CODE_38 = 6'h38;
   localparam logic [5:0] EQ_CODE_34 = 6'h34;
   localparam logic [5:0] EQ_CODE_35 = 6'h35;
   localparam logic [5:0] EQ_CODE_3A = 6'h3A;
   localparam logic [5:0] EQ_CODE_3C = 6'h3C;
   // Swing codes
   localparam logic [5:0] SWING_600MV = 6'h03;
   localparam logic [5:0] SWING_800MV = 6'h07;
   localparam logic [5:0] SWING_1000MV = 6'h0F;
   localparam logic [5:0] SWING_1200MV = 6'h1F;
   localparam logic [5:0] SWING_1400MV = 6'h3F;
   // Three-level strap pin encoding
   typedef enum logic [1:0] {
      STRAP_LOW = 2'h0,
      STRAP_HIGH = 2'h1,
      STRAP_FLOAT = 2'h3
   } lcr_strap_t;
   // Emphasis decode: one-hot of 0/-3.5/-6/-9/-12 dB, bit 5 = unknown or reserved
   localparam logic [5:0] EMPH_SEL_NONE = 6'h01;
   localparam logic [5:0] EMPH_SEL_3P5 = 6'h02;
   localparam logic [5:0] EMPH_SEL_6 = 6'h04;
   localparam logic [5:0] EMPH_SEL_9 = 6'h08;
   localparam logic [5:0] EMPH_SEL_12 = 6'h10;
   localparam logic [5:0] EMPH_SEL_BAD = 6'h20;
   // Swing decode: one-hot of 600..1400 mV, bit 5 = undefined code
   localparam logic [5:0] SWING_SEL_BAD = 6'h20;
endpackage

// File: hdl/lcr_config_regs.sv
`timescale 1ns/10ps
// Overview of operation
// - Emphasis bit 7 selects compatibility or enhanced
// - Emphasis codes decode to five dB levels
// - Emphasis straps map to equivalent register values
// - Threshold upper bits deassert, lower bits assert
// - Threshold codes select four level pairs
// - Bit 5 auto idle, else bit 4
// - Manual idle: 0 active, 1 muted
// - Bit 1 auto rate, else bit 0
// - Manual rate: 0 low band, 1 high
// - Equalizer offers 24 levels, three stages
// - Equalizer enable, gain stage, boost fields
// - Equalizer resets to bypass, straps floating
// - Equalizer straps map to eight codes
// - Swing codes decode to five levels
module lcr_config_regs (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_addr_hit,
   input wire logic strap_mode,
   input wire lcr_pkg::lcr_strap_t emphasis_strap_low,
   input wire lcr_pkg::lcr_strap_t emphasis_strap_high,
   input wire lcr_pkg::lcr_strap_t equalizer_strap_a,
   input wire lcr_pkg::lcr_strap_t equalizer_strap_b,
   output logic [7:0] tx_emphasis_setting,
   output logic emphasis_enhanced,
   output logic [5:0] emphasis_level_sel,
   output logic [1:0] idle_deassert_sel,
   output logic [1:0] idle_assert_sel,
   output logic idle_auto_detect,
   output logic output_muted,
   output logic line_activity_detect_en,
   output logic rate_auto_detect,
   output logic rate_high_band,
   output logic equalizer_enable,
   output logic [1:0] gain_stage_field,
   output logic [2:0] boost_level_field,
   output logic [4:0] equalizer_level,
   output logic [5:0] output_swing_level,
   output logic [5:0] swing_level_sel
);
   import lcr_pkg::*;

   logic [7:0] ch2_out_emphasis, next_ch2_out_emphasis;
   logic [7:0] ch2_idle_threshold, next_ch2_idle_threshold;
   logic [7:0] ch3_idle_rate_select, next_ch3_idle_rate_select;
   logic [7:0] ch3_rx_equalizer, next_ch3_rx_equalizer;
   logic [7:0] ch3_out_swing, next_ch3_out_swing;
   logic [7:0] next_reg_rdata;
   logic next_reg_addr_hit;
   logic [7:0] eff_emphasis;
   logic [5:0] eff_equalizer;
   logic [7:0] next_tx_emphasis_setting;
   logic next_emphasis_enhanced;
   logic [5:0] next_emphasis_level_sel;
   logic [1:0] next_idle_deassert_sel, next_idle_assert_sel;
   logic next_idle_auto_detect, next_output_muted, next_line_activity_detect_en;
   logic next_rate_auto_detect, next_rate_high_band;
   logic next_equalizer_enable;
   logic [1:0] next_gain_stage_field;
   logic [2:0] next_boost_level_field;
   logic [4:0] next_equalizer_level;
   logic [5:0] next_output_swing_level, next_swing_level_sel;

   // Strap pairs to equivalent emphasis register value
   function automatic logic [7:0] emph_from_straps(input lcr_strap_t hi, input lcr_strap_t lo);
      logic [3:0] key;
      key = {hi, lo};
      case (key)
         {STRAP_LOW, STRAP_LOW}: emph_from_straps = EMPH_0DB;
         {STRAP_LOW, STRAP_HIGH}: emph_from_straps = EMPH_3P5DB;
         {STRAP_LOW, STRAP_FLOAT}: emph_from_straps = EMPH_6DB;
         {STRAP_HIGH, STRAP_LOW}: emph_from_straps = EMPH_9DB;
         {STRAP_HIGH, STRAP_FLOAT}: emph_from_straps = EMPH_12DB;
         {STRAP_FLOAT, STRAP_LOW}: emph_from_straps = EMPH_9DB;
         {STRAP_FLOAT, STRAP_HIGH}: emph_from_straps = EMPH_12DB;
         {STRAP_HIGH, STRAP_HIGH}: emph_from_straps = EMPH_12DB;
         // Both floating lands on the reserved code, as a pin user would see
         default: emph_from_straps = EMPH_RESERVED;
      endcase
   endfunction

   // Strap pairs to equivalent equalizer field code
   function automatic logic [5:0] eq_from_straps(input lcr_strap_t a, input lcr_strap_t b);
      logic [3:0] key;
      key = {a, b};
      case (key)
         {STRAP_HIGH, STRAP_HIGH}: eq_from_straps = EQ_CODE_2A;
         {STRAP_LOW, STRAP_LOW}: eq_from_straps = EQ_CODE_30;
         {STRAP_LOW, STRAP_FLOAT}: eq_from_straps = EQ_CODE_31;
         {STRAP_LOW, STRAP_HIGH}: eq_from_straps = EQ_CODE_38;
         {STRAP_HIGH, STRAP_FLOAT}: eq_from_straps = EQ_CODE_34;
         {STRAP_HIGH, STRAP_LOW}: eq_from_straps = EQ_CODE_35;
         {STRAP_FLOAT, STRAP_LOW}: eq_from_straps = EQ_CODE_3A;
         {STRAP_FLOAT, STRAP_HIGH}: eq_from_straps = EQ_CODE_3C;
         default: eq_from_straps = EQ_BYPASS;
      endcase
   endfunction

   // Register write and read port
   always_comb begin
      next_ch2_out_emphasis = ch2_out_emphasis;
      next_ch2_idle_threshold = ch2_idle_threshold;
      next_ch3_idle_rate_select = ch3_idle_rate_select;
      next_ch3_rx_equalizer = ch3_rx_equalizer;
      next_ch3_out_swing = ch3_out_swing;
      next_reg_rdata = 8'h00;
      next_reg_addr_hit = 1'b1;
      // Masking keeps reserved bits zero whatever the host writes
      if (reg_write) begin
         case (reg_addr)
            ADDR_CH2_OUT_EMPHASIS: next_ch2_out_emphasis = reg_wdata & MASK_OUT_EMPHASIS;
            ADDR_CH2_IDLE_THRESHOLD: next_ch2_idle_threshold = reg_wdata & MASK_IDLE_THRESHOLD;
            ADDR_CH3_IDLE_RATE_SELECT: next_ch3_idle_rate_select = reg_wdata & MASK_IDLE_RATE_SELECT;
            ADDR_CH3_RX_EQUALIZER: next_ch3_rx_equalizer = reg_wdata & MASK_RX_EQUALIZER;
            ADDR_CH3_OUT_SWING: next_ch3_out_swing = reg_wdata & MASK_OUT_SWING;
            default: next_reg_addr_hit = 1'b0;
         endcase
      end
      if (reg_read) begin
         case (reg_addr)
            ADDR_CH2_OUT_EMPHASIS: next_reg_rdata = ch2_out_emphasis;
            ADDR_CH2_IDLE_THRESHOLD: next_reg_rdata = ch2_idle_threshold;
            ADDR_CH3_IDLE_RATE_SELECT: next_reg_rdata = ch3_idle_rate_select;
            ADDR_CH3_RX_EQUALIZER: next_reg_rdata = ch3_rx_equalizer;
            ADDR_CH3_OUT_SWING: next_reg_rdata = ch3_out_swing;
            default: next_reg_addr_hit = 1'b0;
         endcase
      end
      if (!reg_write && !reg_read) begin
         next_reg_addr_hit = 1'b0;
      end
   end

   // Decode of stored or strapped settings toward the analog circuits
   always_comb begin
      eff_emphasis = strap_mode ? emph_from_straps(emphasis_strap_high, emphasis_strap_low) : ch2_out_emphasis;
      eff_equalizer = strap_mode ? eq_from_straps(equalizer_strap_a, equalizer_strap_b)
                                 : ch3_rx_equalizer[5:0];
      next_tx_emphasis_setting = eff_emphasis;
      next_emphasis_enhanced = eff_emphasis[EMPH_TYPE_BIT];
      case (eff_emphasis)
         EMPH_0DB: next_emphasis_level_sel = EMPH_SEL_NONE;
         EMPH_3P5DB: next_emphasis_level_sel = EMPH_SEL_3P5;
         EMPH_6DB: next_emphasis_level_sel = EMPH_SEL_6;
         EMPH_9DB: next_emphasis_level_sel = EMPH_SEL_9;
         EMPH_12DB: next_emphasis_level_sel = EMPH_SEL_12;
         // Reserved or undefined code, from the host or the straps, has no defined drive; flag it
         default: next_emphasis_level_sel = EMPH_SEL_BAD;
      endcase
      next_idle_deassert_sel = ch2_idle_threshold[THR_DEASSERT_MSB:THR_DEASSERT_LSB];
      next_idle_assert_sel = ch2_idle_threshold[THR_ASSERT_MSB:0];
      next_idle_auto_detect = ch3_idle_rate_select[IDLE_AUTO_BIT];
      next_output_muted = !ch3_idle_rate_select[IDLE_AUTO_BIT] && ch3_idle_rate_select[IDLE_MUTE_BIT];
      next_line_activity_detect_en = ch3_idle_rate_select[IDLE_AUTO_BIT];
      next_rate_auto_detect = ch3_idle_rate_select[RATE_AUTO_BIT];
      next_rate_high_band = !ch3_idle_rate_select[RATE_AUTO_BIT] && ch3_idle_rate_select[RATE_HIGH_BIT];
      next_equalizer_enable = eff_equalizer[EQ_ENABLE_BIT];
      next_gain_stage_field = eff_equalizer[EQ_STAGE_MSB:EQ_STAGE_LSB];
      next_boost_level_field = eff_equalizer[EQ_BOOST_MSB:0];
      // Flat level 0..23 from stage and boost; stage 3 folds to 2
      if (eff_equalizer[EQ_STAGE_MSB:EQ_STAGE_LSB] == 2'h3) begin
         next_equalizer_level = {2'h2, eff_equalizer[EQ_BOOST_MSB:0]};
      end else begin
         next_equalizer_level = {eff_equalizer[EQ_STAGE_MSB:EQ_STAGE_LSB], eff_equalizer[EQ_BOOST_MSB:0]};
      end
      next_output_swing_level = ch3_out_swing[5:0];
      case (ch3_out_swing[5:0])
         SWING_600MV: next_swing_level_sel = 6'h01;
         SWING_800MV: next_swing_level_sel = 6'h02;
         SWING_1000MV: next_swing_level_sel = 6'h04;
         SWING_1200MV: next_swing_level_sel = 6'h08;
         SWING_1400MV: next_swing_level_sel = 6'h10;
         default: next_swing_level_sel = SWING_SEL_BAD;
      endcase
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ch2_out_emphasis <= RST_OUT_EMPHASIS;
         ch2_idle_threshold <= RST_IDLE_THRESHOLD;
         ch3_idle_rate_select <= RST_IDLE_RATE_SELECT;
         ch3_rx_equalizer <= RST_RX_EQUALIZER;
         ch3_out_swing <= RST_OUT_SWING;
         reg_rdata <= 8'h00;
         reg_addr_hit <= 1'b0;
      end else begin
         ch2_out_emphasis <= next_ch2_out_emphasis;
         ch2_idle_threshold <= next_ch2_idle_threshold;
         ch3_idle_rate_select <= next_ch3_idle_rate_select;
         ch3_rx_equalizer <= next_ch3_rx_equalizer;
         ch3_out_swing <= next_ch3_out_swing;
         reg_rdata <= next_reg_rdata;
         reg_addr_hit <= next_reg_addr_hit;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         tx_emphasis_setting <= RST_OUT_EMPHASIS;
         emphasis_enhanced <= 1'b0;
         emphasis_level_sel <= EMPH_SEL_BAD;
         idle_deassert_sel <= 2'h0;
         idle_assert_sel <= 2'h0;
         idle_auto_detect <= 1'b0;
         output_muted <= 1'b0;
         line_activity_detect_en <= 1'b0;
         rate_auto_detect <= 1'b0;
         rate_high_band <= 1'b0;
         equalizer_enable <= 1'b1;
         gain_stage_field <= 2'h0;
         boost_level_field <= 3'h0;
         equalizer_level <= 5'h00;
         output_swing_level <= SWING_600MV;
         swing_level_sel <= 6'h01;
      end else begin
         tx_emphasis_setting <= next_tx_emphasis_setting;
         emphasis_enhanced <= next_emphasis_enhanced;
         emphasis_level_sel <= next_emphasis_level_sel;
         idle_deassert_sel <= next_idle_deassert_sel;
         idle_assert_sel <= next_idle_assert_sel;
         idle_auto_detect <= next_idle_auto_detect;
         output_muted <= next_output_muted;
         line_activity_detect_en <= next_line_activity_detect_en;
         rate_auto_detect <= next_rate_auto_detect;
         rate_high_band <= next_rate_high_band;
         equalizer_enable <= next_equalizer_enable;
         gain_stage_field <= next_gain_stage_field;
         boost_level_field <= next_boost_level_field;
         equalizer_level <= next_equalizer_level;
         output_swing_level <= next_output_swing_level;
         swing_level_sel <= next_swing_level_sel;
      end
   end
endmodule

// File: sim/lcr_config_regs_checker.sv
`timescale 1ns/10ps
module lcr_config_regs_checker
   import lcr_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_addr_hit,
   input wire logic [7:0] tx_emphasis_setting,
   input wire logic emphasis_enhanced,
   input wire logic [1:0] idle_deassert_sel,
   input wire logic [1:0] idle_assert_sel,
   input wire logic idle_auto_detect,
   input wire logic output_muted,
   input wire logic line_activity_detect_en,
   input wire logic rate_auto_detect,
   input wire logic rate_high_band,
   input wire logic [1:0] gain_stage_field,
   input wire logic [2:0] boost_level_field,
   input wire logic [4:0] equalizer_level,
   input wire logic [5:0] output_swing_level
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   emph_type_a: assert property ($stable(tx_emphasis_setting) |-> emphasis_enhanced == tx_emphasis_setting[7])
      else $error("emphasis type bit mismatch");
   thresh_split_a: assert property (reg_write && reg_addr == ADDR_CH2_IDLE_THRESHOLD |->
      ##2 {4'h0, idle_deassert_sel, idle_assert_sel} == ($past(reg_wdata, 2) & 8'h0F)) else $error("threshold fields wrong");
   idle_manual_a: assert property (output_muted |-> !idle_auto_detect && !line_activity_detect_en)
      else $error("muted while idle auto");
   rate_manual_a: assert property (rate_high_band |-> !rate_auto_detect)
      else $error("manual rate while rate auto");
   eq_level_a: assert property ($stable(gain_stage_field) && $stable(boost_level_field) |->
      equalizer_level == {(gain_stage_field == 2'h3) ? 2'h2 : gain_stage_field, boost_level_field})
      else $error("equalizer level wrong");
   swing_write_a: assert property (reg_write && reg_addr == ADDR_CH3_OUT_SWING |->
      ##2 {2'h0, output_swing_level} == ($past(reg_wdata, 2) & 8'h3F)) else $error("swing field wrong");
   swing_read_a: assert property (reg_read && reg_addr == ADDR_CH3_OUT_SWING |=> reg_addr_hit && reg_rdata[7:6] == 2'h0)
      else $error("swing upper bits not zero");
   unmapped_read_a: assert property (reg_read && !(reg_addr inside {[8'h1F:8'h20], [8'h23:8'h25]}) |=>
      reg_rdata == 8'h00 && !reg_addr_hit) else $error("unmapped read answered");
endmodule
bind lcr_config_regs lcr_config_regs_checker i_checker (.clock, .reset_n, .reg_write, .reg_read, .reg_addr,
   .reg_wdata, .reg_rdata, .reg_addr_hit, .tx_emphasis_setting, .emphasis_enhanced, .idle_deassert_sel,
   .idle_assert_sel, .idle_auto_detect, .output_muted, .line_activity_detect_en, .rate_auto_detect,
   .rate_high_band, .gain_stage_field, .boost_level_field, .equalizer_level, .output_swing_level);

// File: sim/lcr_host_model.sv
`timescale 1ns/10ps
module lcr_host_model (
   input wire logic clock,
   input wire logic [7:0] reg_rdata,
   output logic reg_write = 1'b0,
   output logic reg_read = 1'b0,
   output logic [7:0] reg_addr = 8'hA5,
   output logic [7:0] reg_wdata = 8'h5A
);
   import lcr_pkg::*;
   // Host skips writes of the reserved emphasis code; other data goes out unmasked
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      if (addr == ADDR_CH2_OUT_EMPHASIS && data == EMPH_RESERVED) begin
         return;
      end
      @(posedge clock);
      #1;
      {reg_addr, reg_wdata, reg_write} = {addr, data, 1'b1};
      @(posedge clock);
      #1;
      // Released lines flip so stale values never look valid
      {reg_addr, reg_wdata, reg_write} = {~addr, ~data, 1'b0};
   endtask
   task automatic rd(input logic [7:0] addr, output logic [7:0] data);
      @(posedge clock);
      #1;
      {reg_addr, reg_read} = {addr, 1'b1};
      @(posedge clock);
      #1;
      data = reg_rdata;
      {reg_addr, reg_read} = {~addr, 1'b0};
   endtask
endmodule

// File: sim/lcr_config_regs_tb_top.sv
`timescale 1ns/10ps
module lcr_config_regs_tb_top;
   import lcr_pkg::*;
   logic clock = 1'b0, reset_n = 1'b0, strap_mode = 1'b0;
   logic reg_write, reg_read, reg_addr_hit, emphasis_enhanced, idle_auto_detect, output_muted;
   logic line_activity_detect_en, rate_auto_detect, rate_high_band, equalizer_enable;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, tx_emphasis_setting;
   logic [5:0] emphasis_level_sel, output_swing_level, swing_level_sel;
   logic [1:0] idle_deassert_sel, idle_assert_sel, gain_stage_field;
   logic [2:0] boost_level_field;
   logic [4:0] equalizer_level;
   lcr_strap_t emphasis_strap_low = STRAP_FLOAT, emphasis_strap_high = STRAP_FLOAT;
   lcr_strap_t equalizer_strap_a = STRAP_FLOAT, equalizer_strap_b = STRAP_FLOAT;
   int err_count = 0;
   int samples_checked = 0;
   always #20 clock = ~clock;
   lcr_config_regs i_dut (.clock, .reset_n, .reg_write, .reg_read, .reg_addr, .reg_wdata, .reg_rdata,
      .reg_addr_hit, .strap_mode, .emphasis_strap_low, .emphasis_strap_high, .equalizer_strap_a,
      .equalizer_strap_b, .tx_emphasis_setting, .emphasis_enhanced, .emphasis_level_sel, .idle_deassert_sel,
      .idle_assert_sel, .idle_auto_detect, .output_muted, .line_activity_detect_en, .rate_auto_detect,
      .rate_high_band, .equalizer_enable, .gain_stage_field, .boost_level_field, .equalizer_level,
      .output_swing_level, .swing_level_sel);
   lcr_host_model i_host (.clock, .reg_rdata, .reg_write, .reg_read, .reg_addr, .reg_wdata);
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic settle();
      repeat (3) @(posedge clock);
      #1;
   endtask
   task automatic t_regs();
      logic [7:0] d;
      logic [7:0] addrs [6] = '{8'h1F, 8'h20, 8'h23, 8'h24, 8'h25, 8'h21};
      logic [7:0] rsts [6] = '{8'h03, 8'h00, 8'h00, 8'h20, 8'h03, 8'h00};
      chk({2'h0, equalizer_enable, gain_stage_field, boost_level_field}, 8'h20);
      i_host.wr(8'h21, 8'h55);
      for (int i = 0; i < 6; i++) begin
         i_host.rd(addrs[i], d);
         chk(d, rsts[i]);
      end
      i_host.wr(ADDR_CH3_OUT_SWING, 8'hFF);
      i_host.rd(ADDR_CH3_OUT_SWING, d);
      chk(d, 8'h3F);
      i_host.wr(ADDR_CH3_OUT_SWING, 8'h05);
      settle();
      chk({2'h0, output_swing_level}, 8'h05);
      chk({2'h0, swing_level_sel}, 8'h20);
      $display("test registers done");
   endtask
   task automatic t_codes();
      logic [5:0] sw [5] = '{6'h03, 6'h07, 6'h0F, 6'h1F, 6'h3F};
      logic [7:0] em [5] = '{8'h01, 8'h38, 8'h88, 8'h90, 8'hA0};
      for (int i = 0; i < 5; i++) begin
         i_host.wr(ADDR_CH3_OUT_SWING, {2'h0, sw[i]});
         i_host.wr(ADDR_CH2_OUT_EMPHASIS, em[i]);
         settle();
         chk({2'h0, swing_level_sel}, 8'h01 << i);
         chk({2'h0, emphasis_level_sel}, 8'h01 << i);
         chk({7'h0, emphasis_enhanced}, {7'h0, em[i][7]});
      end
      $display("test codes done");
   endtask
   task automatic t_idle_eq();
      logic [7:0] v [6] = '{8'h10, 8'h30, 8'h01, 8'h03, 8'h20, 8'h00};
      logic [7:0] eq [3] = '{8'h3B, 8'h15, 8'h07};
      logic [7:0] lvl [3] = '{8'h13, 8'h15, 8'h07};
      for (int i = 0; i < 6; i++) begin
         i_host.wr(ADDR_CH3_IDLE_RATE_SELECT, v[i]);
         i_host.wr(ADDR_CH2_IDLE_THRESHOLD, {4'h0, v[i][1:0], ~v[i][1:0]});
         if (i < 3) begin
            i_host.wr(ADDR_CH3_RX_EQUALIZER, eq[i]);
         end
         settle();
         chk({3'h0, idle_auto_detect, output_muted, line_activity_detect_en, rate_auto_detect, rate_high_band},
            {3'h0, v[i][5], ~v[i][5] & v[i][4], v[i][5], v[i][1], ~v[i][1] & v[i][0]});
         chk({4'h0, idle_deassert_sel, idle_assert_sel}, {4'h0, v[i][1:0], ~v[i][1:0]});
         if (i < 3) begin
            chk({2'h0, equalizer_enable, gain_stage_field, boost_level_field}, eq[i] & 8'h3F);
            chk({3'h0, equalizer_level}, lvl[i]);
         end
      end
      $display("test idle and equalizer done");
   endtask
   task automatic t_straps();
      logic [9:0] eqt [9] = '{{2'h3, 2'h3, 6'h20}, {2'h1, 2'h1, 6'h2A}, {2'h0, 2'h0, 6'h30}, {2'h0, 2'h3, 6'h31},
         {2'h0, 2'h1, 6'h38}, {2'h1, 2'h3, 6'h34}, {2'h1, 2'h0, 6'h35}, {2'h3, 2'h0, 6'h3A}, {2'h3, 2'h1, 6'h3C}};
      logic [11:0] emt [5] = '{{2'h0, 2'h0, 8'h01}, {2'h0, 2'h3, 8'h88}, {2'h1, 2'h3, 8'hA0}, {2'h3, 2'h0, 8'h90},
         {2'h3, 2'h3, 8'hC0}};
      strap_mode = 1'b1;
      for (int i = 0; i < 9; i++) begin
         equalizer_strap_a = lcr_strap_t'(eqt[i][9:8]);
         equalizer_strap_b = lcr_strap_t'(eqt[i][7:6]);
         if (i < 5) begin
            emphasis_strap_high = lcr_strap_t'(emt[i][11:10]);
            emphasis_strap_low = lcr_strap_t'(emt[i][9:8]);
         end
         settle();
         chk({2'h0, equalizer_enable, gain_stage_field, boost_level_field}, {2'h0, eqt[i][5:0]});
         if (i < 5) begin
            chk(tx_emphasis_setting, emt[i][7:0]);
         end
      end
      // Both emphasis straps floating leave the reserved code in force
      chk({2'h0, emphasis_level_sel}, 8'h20);
      strap_mode = 1'b0;
      settle();
      chk(tx_emphasis_setting, 8'hA0);
      $display("test straps done");
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clock);
      #1;
      reset_n = 1'b1;
      t_regs();
      t_codes();
      t_idle_eq();
      t_straps();
      results();
   end
   initial begin
      #200000;
      err_count++;
      $display("unexpected at %0t: watchdog expired", $time);
      results();
   end
endmodule
